//--- pkg/spt_defines.vh
/*
 constants for the per-port frame policy block: register byte offsets,
 field positions and reset values. assumes word-aligned axi4-lite access.
*/
`ifndef SPT_DEFINES_VH
`define SPT_DEFINES_VH
// ----------------------------------------------------------------------
// register byte offsets (per-port groups step by 4 per port)
// ----------------------------------------------------------------------
`define SPT_GRP_CTRL0     4'h0
`define SPT_GRP_CTRL2     4'h1
`define SPT_GRP_DEFTAG    4'h2
`define SPT_GRP_INSSRC    4'h3
`define SPT_OFF_PCPMAP    8'h40
`define SPT_OFF_FLUSH     8'h44
`define SPT_OFF_STATUS    8'h48
`define SPT_GRP_DSCP      4'h5
// ----------------------------------------------------------------------
// control 0 fields
// ----------------------------------------------------------------------
`define SPT_C0_QLO        0
`define SPT_C0_REMOVE     1
`define SPT_C0_INSERT     2
`define SPT_C0_PCP_EN     5
`define SPT_C0_DSCP_EN    6
// ----------------------------------------------------------------------
// control 2 fields
// ----------------------------------------------------------------------
`define SPT_C2_LRN_DIS    0
`define SPT_C2_RX_EN      1
`define SPT_C2_TX_EN      2
`define SPT_C2_QHI        3
`define SPT_C2_CEIL       7
// ----------------------------------------------------------------------
// flush control fields and misc
// ----------------------------------------------------------------------
`define SPT_FL_STATIC     4
`define SPT_FL_DYNAMIC    5
`define SPT_RST_CTRL0     8'h00
`define SPT_RST_CTRL2     8'h07
`define SPT_RST_DEFTAG    16'h0001
`define SPT_RST_INSSRC    4'hf
`define SPT_RST_PCPMAP    16'hfa50
`define SPT_RST_DSCP      32'h00000000
`define SPT_TPID          16'h8100
`define SPT_ACT_PASS      2'h0
`define SPT_ACT_INSERT    2'h1
`define SPT_ACT_REMOVE    2'h2
`define SPT_RESP_OKAY     2'h0
`define SPT_RESP_SLVERR   2'h2
`endif

//--- rtl/spt_policy.v
/*
 per-port frame policy: 802.1p and dscp priority classification, priority
 ceiling, egress tag insert/remove decision, spanning-tree gating, flush
 requests and queue-split mode, with registers on axi4-lite.
 assumes the frame datapath presents one decision request per cycle at most
 per request group and consumes each answer one cycle later.
*/
// Functional notes
// RULE_01: tagged ingress user priority maps through programmable 3-to-2-bit table.
// RULE_02: tag priority classification only when port control 0 bit 5 set.
// RULE_03: the handled tag is four bytes: two-byte tpid then two-byte tci.
// RULE_04: insertion enabled by control 0 bit 2, gated by ingress-port select.
// RULE_05: insert ingress default tag on untagged frames only, never double tag.
// RULE_06: each of four ports holds its own default tag with vid and priority.
// RULE_07: control 0 bit 1 strips tags on egress; untagged frames pass unchanged.
// RULE_08: frame check sequence is regenerated whenever a tag is added or removed.
// RULE_09: ceiling bit 7 of control 2 clamps priority to default-tag priority.
// RULE_10: upper six tos bits pick a two-bit field of the 128-bit dscp table.
// RULE_11: processor port is designated; ports 1-3 have tx, rx, learn-disable (code: CPU_PORT is port 3; ports 0-2 have them).
// RULE_12: tx=rx=0 with learning disabled: no user traffic, no learning.
// RULE_13: blocking forwards only processor-bound frames and learns nothing.
// RULE_14: listening still passes frames to and from processor, no learning.
// RULE_15: tx=rx=0 with learning on: learn, pass only processor traffic.
// RULE_16: tx=rx=1 with learning on: forward, receive and learn normally.
// RULE_17: static override match reaches the processor even when port blocks.
// RULE_18: flush bits 5 and 4 purge entries of ports with learning disabled.
// RULE_19: processor sends nothing to disabled ports, drops override leftovers.
// RULE_20: processor programs override static entries such as bpdu addresses.
// RULE_21: rstp discarding equals disable, blocking and listening combined.
// RULE_22: two-bit queue split per port: 00 one, 01 two, 10 four queues.
`include "spt_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module spt_policy #(
  parameter CPU_PORT = 3
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        cls_req,
  input  wire [1:0]  cls_port,
  input  wire        cls_tagged,
  input  wire [2:0]  cls_pcp,
  input  wire        cls_ip,
  input  wire [7:0]  cls_tos,
  output reg         cls_valid,
  output reg  [1:0]  cls_prio,
  output reg  [2:0]  cls_pcp_out,
  input  wire        eg_req,
  input  wire [1:0]  eg_port,
  input  wire [1:0]  eg_src,
  input  wire        eg_tagged,
  output reg         eg_valid,
  output reg  [1:0]  eg_action,
  output reg  [31:0] eg_tag,
  output reg         eg_crc_regen,
  input  wire        fwd_req,
  input  wire [1:0]  fwd_src,
  input  wire [1:0]  fwd_dst,
  input  wire        fwd_ovr,
  output reg         fwd_valid,
  output reg         fwd_allow,
  output reg         fwd_learn,
  output reg         flush_dyn,
  output reg         flush_sta,
  output reg  [3:0]  flush_ports,
  output reg  [7:0]  q_mode
);

  // --------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------
  reg [7:0]   ctrl0_q  [0:3];
  reg [7:0]   ctrl2_q  [0:3];
  reg [15:0]  deftag_q [0:3];
  reg [3:0]   inssrc_q [0:3];
  reg [31:0]  dscp_q   [0:3];
  reg [15:0]  pcpmap_q;
  reg [15:0]  edits_q;
  reg         aw_have_q;
  reg         w_have_q;
  reg [7:0]   awaddr_q;
  reg [31:0]  wdata_q;
  reg [3:0]   wstrb_q;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function [31:0] strb_mask;
    input [3:0] s;
    begin
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a[1:0] == 2'h0) &&
                ((a[7:4] <= `SPT_GRP_INSSRC) || (a[7:4] == `SPT_GRP_DSCP) ||
                 (a == `SPT_OFF_PCPMAP) || (a == `SPT_OFF_FLUSH) ||
                 (a == `SPT_OFF_STATUS));
    end
  endfunction

  // user-traffic gates; the processor port is always open
  function port_rx;
    input [1:0] p;
    begin
      port_rx = (p == CPU_PORT) || ctrl2_q[p][`SPT_C2_RX_EN];
    end
  endfunction

  function port_tx;
    input [1:0] p;
    begin
      port_tx = (p == CPU_PORT) || ctrl2_q[p][`SPT_C2_TX_EN];
    end
  endfunction

  function port_lrn;
    input [1:0] p;
    begin
      port_lrn = (p == CPU_PORT) || !ctrl2_q[p][`SPT_C2_LRN_DIS];
    end
  endfunction

  // --------------------------------------------------------------------
  // axi4-lite write path
  // --------------------------------------------------------------------
  wire        wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
  wire [31:0] wmask  = strb_mask(wstrb_q);
  wire [31:0] wbits  = wdata_q & wmask;
  wire [1:0]  wport  = awaddr_q[3:2];
  wire        wr_ok  = addr_ok(awaddr_q);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SPT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SPT_RESP_OKAY : `SPT_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_have_q     <= 1'b0;
        w_have_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // register file, one generate slice per port
  // --------------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp = gp + 1)
    begin : g_port
      wire hit = wr_go && wr_ok && (wport == gp);
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          ctrl0_q[gp]  <= `SPT_RST_CTRL0;
          ctrl2_q[gp]  <= `SPT_RST_CTRL2;
          deftag_q[gp] <= `SPT_RST_DEFTAG;
          inssrc_q[gp] <= `SPT_RST_INSSRC;
          dscp_q[gp]   <= `SPT_RST_DSCP;
        end
        else if (hit)
        begin
          case (awaddr_q[7:4])
            `SPT_GRP_CTRL0:
              ctrl0_q[gp] <= (ctrl0_q[gp] & ~wmask[7:0]) | wbits[7:0];
            `SPT_GRP_CTRL2:
              ctrl2_q[gp] <= (ctrl2_q[gp] & ~wmask[7:0]) | wbits[7:0];
            `SPT_GRP_DEFTAG: // see RULE_06
              deftag_q[gp] <= (deftag_q[gp] & ~wmask[15:0]) | wbits[15:0];
            `SPT_GRP_INSSRC:
              inssrc_q[gp] <= (inssrc_q[gp] & ~wmask[3:0]) | wbits[3:0];
            `SPT_GRP_DSCP: // see RULE_10
              dscp_q[gp] <= (dscp_q[gp] & ~wmask) | wbits;
            default:
              ctrl0_q[gp] <= ctrl0_q[gp];
          endcase
        end
      end
    end
  endgenerate

  // pcp map and flush pulses; flush bits self-clear so they read as zero
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pcpmap_q    <= `SPT_RST_PCPMAP;
      flush_dyn   <= 1'b0;
      flush_sta   <= 1'b0;
      flush_ports <= 4'h0;
    end
    else
    begin
      flush_dyn <= 1'b0;
      flush_sta <= 1'b0;
      if (wr_go && awaddr_q == `SPT_OFF_PCPMAP)
        pcpmap_q <= (pcpmap_q & ~wmask[15:0]) | wbits[15:0];
      if (wr_go && awaddr_q == `SPT_OFF_FLUSH)
      begin
        // only ports with learning disabled are purged; see RULE_18
        flush_dyn   <= wbits[`SPT_FL_DYNAMIC];
        flush_sta   <= wbits[`SPT_FL_STATIC];
        flush_ports <= {1'b0, ctrl2_q[2][`SPT_C2_LRN_DIS],
                        ctrl2_q[1][`SPT_C2_LRN_DIS],
                        ctrl2_q[0][`SPT_C2_LRN_DIS]};
      end
    end
  end

  // --------------------------------------------------------------------
  // axi4-lite read path
  // --------------------------------------------------------------------
  reg  [31:0] rd_d;
  wire [1:0]  rport = s_axi_araddr[3:2];

  always @*
  begin
    rd_d = 32'h00000000;
    case (s_axi_araddr[7:4])
      `SPT_GRP_CTRL0:  rd_d = {24'h000000, ctrl0_q[rport]};
      `SPT_GRP_CTRL2:  rd_d = {24'h000000, ctrl2_q[rport]};
      `SPT_GRP_DEFTAG: rd_d = {16'h0000, deftag_q[rport]};
      `SPT_GRP_INSSRC: rd_d = {28'h0000000, inssrc_q[rport]};
      `SPT_GRP_DSCP:   rd_d = dscp_q[rport];
      default:
      begin
        if (s_axi_araddr == `SPT_OFF_PCPMAP)
          rd_d = {16'h0000, pcpmap_q};
        else if (s_axi_araddr == `SPT_OFF_STATUS)
          rd_d = {8'h00, q_mode, edits_q};
        else
          rd_d = 32'h00000000;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SPT_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= addr_ok(s_axi_araddr) ? rd_d : 32'h00000000;
      s_axi_rresp   <= addr_ok(s_axi_araddr) ? `SPT_RESP_OKAY
                                             : `SPT_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // ingress classification
  // --------------------------------------------------------------------
  wire [2:0] def_pcp  = deftag_q[cls_port][15:13];
  wire       ceil_on  = ctrl2_q[cls_port][`SPT_C2_CEIL];
  wire [2:0] pcp_eff  = (ceil_on && cls_pcp > def_pcp) ? def_pcp
                                                       : cls_pcp; // see RULE_09
  wire [1:0] pcp_prio = pcpmap_q[{pcp_eff, 1'b0} +: 2];       // see RULE_01
  wire [5:0] dscp     = cls_tos[7:2];
  wire [6:0] dbit     = {dscp, 1'b0};
  wire [1:0] dscp_pri = dscp_q[cls_port] == dscp_q[cls_port] ?
                        dscp_q[dbit[6:5]][dbit[4:0] +: 2] : 2'h0;
  wire       use_pcp  = cls_tagged && ctrl0_q[cls_port][`SPT_C0_PCP_EN];
  wire       use_dscp = cls_ip && ctrl0_q[cls_port][`SPT_C0_DSCP_EN];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cls_valid   <= 1'b0;
      cls_prio    <= 2'h0;
      cls_pcp_out <= 3'h0;
    end
    else
    begin
      cls_valid <= cls_req;
      if (cls_req)
      begin
        if (use_pcp)                   // see RULE_02
          cls_prio <= pcp_prio;        // see RULE_01
        else if (use_dscp)
          cls_prio <= dscp_pri;        // see RULE_10
        else
          cls_prio <= 2'h0;
        cls_pcp_out <= pcp_eff;        // see RULE_09
      end
    end
  end

  // --------------------------------------------------------------------
  // egress tag handling
  // --------------------------------------------------------------------
  wire do_ins = ctrl0_q[eg_port][`SPT_C0_INSERT] &&
                inssrc_q[eg_port][eg_src] && !eg_tagged; // see RULE_04 RULE_05
  wire do_rem = ctrl0_q[eg_port][`SPT_C0_REMOVE] && eg_tagged; // see RULE_07

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      eg_valid     <= 1'b0;
      eg_action    <= `SPT_ACT_PASS;
      eg_tag       <= 32'h00000000;
      eg_crc_regen <= 1'b0;
      edits_q      <= 16'h0000;
    end
    else
    begin
      eg_valid <= eg_req;
      if (eg_req)
      begin
        if (do_ins)        // see RULE_05
          eg_action <= `SPT_ACT_INSERT;
        else if (do_rem)   // see RULE_07
          eg_action <= `SPT_ACT_REMOVE;
        else
          eg_action <= `SPT_ACT_PASS;
        eg_tag       <= {`SPT_TPID, deftag_q[eg_src]};  // see RULE_03
        eg_crc_regen <= do_ins || do_rem;               // see RULE_08
        if (do_ins || do_rem)
          edits_q <= edits_q + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // spanning-tree forwarding gate
  // --------------------------------------------------------------------
  // disable, blocking and listening share one setting, so override frames
  // to the processor are the only way out of those ports
  wire src_cpu  = (fwd_src == CPU_PORT);
  wire dst_cpu  = (fwd_dst == CPU_PORT);
  wire to_cpu   = dst_cpu && (port_rx(fwd_src) || fwd_ovr ||
                              port_lrn(fwd_src)); // see RULE_13 RULE_15 RULE_17
  wire from_cpu = src_cpu;                        // see RULE_14
  wire user_ok  = port_rx(fwd_src) && port_tx(fwd_dst); // see RULE_12 RULE_16

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fwd_valid <= 1'b0;
      fwd_allow <= 1'b0;
      fwd_learn <= 1'b0;
    end
    else
    begin
      fwd_valid <= fwd_req;
      if (fwd_req)
      begin
        fwd_allow <= to_cpu || from_cpu || user_ok; // see RULE_11 RULE_21
        fwd_learn <= port_lrn(fwd_src);             // see RULE_12 RULE_15
      end
    end
  end

  // --------------------------------------------------------------------
  // queue split mode per port
  // --------------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
      q_mode <= 8'h00;
    else   // see RULE_22
      q_mode <= {ctrl2_q[3][`SPT_C2_QHI], ctrl0_q[3][`SPT_C0_QLO],
                 ctrl2_q[2][`SPT_C2_QHI], ctrl0_q[2][`SPT_C0_QLO],
                 ctrl2_q[1][`SPT_C2_QHI], ctrl0_q[1][`SPT_C0_QLO],
                 ctrl2_q[0][`SPT_C2_QHI], ctrl0_q[0][`SPT_C0_QLO]};
  end

endmodule // spt_policy

`default_nettype wire

//--- test/spt_host_model.sv
/*
 host processor model on the forwarding request group.
 assumes the bench keeps blk_mask at the ports now disabled or blocking.
*/
`timescale 1ns/1ns
`default_nettype none
module spt_host_model (
  input  wire logic       aclk,
  input  wire logic [3:0] blk_mask,
  output var  logic       fwd_req,
  output var  logic [1:0] fwd_src,
  output var  logic [1:0] fwd_dst,
  output var  logic       fwd_ovr
);
  initial
  begin
    fwd_req = 1'b0;
    fwd_src = 2'h0;
    fwd_dst = 2'h0;
    fwd_ovr = 1'b0;
  end
  // o marks a hit on a static entry the host set with override
  task automatic send(input logic [1:0] s, d, input logic o, output logic ok);
    ok = !(s == 2'h3 && blk_mask[d]);
    @(posedge aclk);
    fwd_req <= ok;
    fwd_src <= s;
    fwd_dst <= d;
    fwd_ovr <= o;
  endtask
  // released fwd_src and fwd_dst toggle so a stale value is never mistaken for data
  task automatic idle;
    @(posedge aclk);
    fwd_req <= 1'b0;
    fwd_src <= ~fwd_src;
    fwd_dst <= ~fwd_dst;
  endtask
endmodule // spt_host_model
`default_nettype wire

//--- test/spt_policy_assertions.sv
/*
 port checker for spt_policy: answer timing, tag edits, forwarding, flush.
 assumes it is bound to spt_policy and sees its ports only.
*/
`timescale 1ns/1ns
`default_nettype none
module spt_policy_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        cls_req,
  input wire logic        cls_valid,
  input wire logic        eg_req,
  input wire logic        eg_tagged,
  input wire logic        eg_valid,
  input wire logic [1:0]  eg_action,
  input wire logic [31:0] eg_tag,
  input wire logic        eg_crc_regen,
  input wire logic        fwd_req,
  input wire logic [1:0]  fwd_src,
  input wire logic        fwd_valid,
  input wire logic        fwd_allow,
  input wire logic        fwd_learn,
  input wire logic        flush_dyn,
  input wire logic [3:0]  flush_ports,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // sequences
  // ----
  sequence b_hs_s;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence ins_s;
    eg_valid && eg_action == 2'h1;
  endsequence
  // ----
  // properties
  // ----
  cls_answer_a: assert property (cls_req |=> cls_valid)
    else $error("classify answer missing");
  eg_no_dbl_a: assert property (eg_req && eg_tagged |=>
    eg_valid && eg_action != 2'h1) else $error("tagged frame got a tag");
  eg_plain_a: assert property (eg_req && !eg_tagged |=>
    eg_valid && eg_action != 2'h2) else $error("untagged frame stripped");
  crc_regen_a: assert property (eg_valid |->
    eg_crc_regen == (eg_action != 2'h0)) else $error("crc regen wrong");
  tag_tpid_a: assert property (ins_s |->
    eg_tag[31:16] == 16'h8100) else $error("inserted tag id wrong");
  cpu_src_a: assert property (fwd_req && fwd_src == 2'h3 |=>
    fwd_valid && fwd_allow && fwd_learn) else $error("cpu frame held");
  flush_pulse_a: assert property (flush_dyn |->
    $rose(s_axi_bvalid) && !flush_ports[3] ##1 !flush_dyn)
    else $error("flush pulse misplaced");
  // the next write must be accepted right after the response is taken
  wr_release_a: assert property (b_hs_s |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not released");
endmodule // spt_policy_assertions
bind spt_policy spt_policy_assertions i_chk (.*);
`default_nettype wire

//--- test/spt_policy_tb_top.sv
/*
 self-checking bench for spt_policy: axi4-lite tasks, request drivers with
 result queues, host model on forwarding. assumes the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module spt_policy_tb_top;
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, cls_tos = '0, q_mode;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, eg_tag;
  logic [3:0]  s_axi_wstrb = 4'hf, blk = '0, flush_ports;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, cls_port = '0, cls_prio;
  logic [1:0]  eg_port = '0, eg_src = '0, eg_action, fwd_src, fwd_dst;
  logic        cls_req = 0, cls_tagged = 1, cls_ip = 0, cls_valid;
  logic [2:0]  cls_pcp = '0, cls_pcp_out, st[4], q;
  logic        eg_req = 0, eg_tagged = 0, eg_valid, eg_crc_regen;
  logic        fwd_req, fwd_ovr, fwd_valid, fwd_allow, fwd_learn;
  logic        flush_dyn, flush_sta;
  logic [39:0] cq[$], eq[$], fq[$], bq[$], rq[$], lq[$];
  logic [31:0] dt[4], m, t;
  logic [15:0] tg[4];
  logic [5:0]  d;
  int          failures = 0, total_checks = 0, n_mod = 0;
  spt_policy i_dut (.*);
  spt_host_model i_host (.aclk, .blk_mask(blk), .fwd_req, .fwd_src,
    .fwd_dst, .fwd_ovr);
  always #4 aclk = ~aclk;
  // ----
  // checking
  // ----
  task automatic chk(input string n, input logic [39:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("failures %0d total_checks %0d", failures, total_checks);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tmo;
    chk("wait", 1, 0);
    end_sim;
  endtask
  // an answer with no note pops x and so always mismatches
  function automatic logic [39:0] pk(ref logic [39:0] qq[$]);
    return qq.size() ? qq.pop_front() : 'x;
  endfunction
  always @(posedge aclk)
  begin
    if (cls_valid) chk("cls", {cls_prio, cls_pcp_out}, pk(cq));
    if (eg_valid) chk("eg", {eg_action, eg_crc_regen, eg_tag}, pk(eq));
    if (fwd_valid) chk("fwd", {fwd_allow, fwd_learn}, pk(fq));
    if (s_axi_bvalid && s_axi_bready) chk("bresp", s_axi_bresp, pk(bq));
    if (s_axi_rvalid && s_axi_rready) chk("rd", {s_axi_rresp, s_axi_rdata},
      pk(rq));
    if (flush_dyn || flush_sta) chk("flush", {flush_dyn, flush_sta,
      flush_ports}, pk(lq));
  end
  // ----
  // drivers
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] r = 2'h0);
    int n;
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    if (n == 50) tmo;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 0;
    if (n == 50) tmo;
  endtask
  task automatic cls(input logic [1:0] p, input logic [2:0] c,
    input logic i, input logic [7:0] tos, input logic [4:0] e);
    @(posedge aclk);
    cls_req <= 1;
    cls_port <= p;
    cls_pcp <= c;
    cls_ip <= i;
    cls_tos <= tos;
    cq.push_back(e);
  endtask
  // port 2 inserts for sources 0 and 2 and strips; port 1 passes all
  task automatic eg(input logic [1:0] p, s, input logic tgd);
    logic [1:0] a;
    a = p != 2 ? 2'h0 : tgd ? 2'h2 : s[0] ? 2'h0 : 2'h1;
    n_mod += a != 0;
    @(posedge aclk);
    eg_req <= 1;
    eg_port <= p;
    eg_src <= s;
    eg_tagged <= tgd;
    eq.push_back({a, a != 2'h0, 16'h8100, tg[s]});
  endtask
  task automatic fw(input logic [1:0] s, dd, input logic o);
    logic ok;
    logic [2:0] a, b;
    a = st[s];
    b = st[dd];
    i_host.send(s, dd, o, ok);
    if (ok) fq.push_back({s == 3 || (dd == 3 ? a[1] || o || !a[0] :
      a[1] && b[2]), s == 3 || !a[0]});
  endtask
  task automatic idle;
    @(posedge aclk);
    cls_req <= 0;
    eg_req <= 0;
  endtask
  // ----
  // scenarios
  // ----
  initial
  begin
    void'($urandom(41));
    st[3] = 3'h7;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00, 34'h0);
    rd(8'h10, 34'h7);
    rd(8'h20, 34'h1);
    rd(8'h30, 34'hf);
    rd(8'h40, 34'hfa50);
    rd(8'h44, 34'h0);
    rd(8'h50, 34'h0);
    rd(8'h4c, {2'h2, 32'h0});
    wr(8'h4c, 32'h1, 2'h2);
    wr(8'h01, 32'h1, 2'h2);
    for (int p = 0; p < 4; p++)
    begin
      tg[p] = {3'(3 - p), 1'b0, 12'($urandom)};
      wr(8'(8'h20 + 4 * p), tg[p]);
      rd(8'(8'h20 + 4 * p), tg[p]);
    end
    m = $urandom & 32'hffff;
    wr(8'h40, m);
    for (int j = 0; j < 3; j++)
    begin
      wr(8'h00, j == 2 ? 32'h0 : 32'h20);
      wr(8'h10, j == 1 ? 32'h87 : 32'h07);
      for (int i = 0; i < 8; i++)
      begin
        q = (j == 1 && i > 3) ? 3'h3 : 3'(i);
        cls(0, 3'(i), 1'($urandom), 8'($urandom), {j == 2 ? 2'h0 :
          m[2 * q +: 2], q});
      end
      idle;
    end
    wr(8'h04, 32'h41);
    for (int w = 0; w < 4; w++)
    begin
      dt[w] = $urandom;
      wr(8'(8'h50 + 4 * w), dt[w]);
    end
    for (int i = 0; i < 12; i++)
    begin
      t = $urandom;
      d = t[7:2];
      cls(1, 3'(i), t[8], t[7:0], {t[8] ? dt[d[5:4]][2 * d[3:0] +: 2] :
        2'h0, 3'(i)});
    end
    idle;
    wr(8'h08, 32'h06);
    wr(8'h38, 32'h5);
    wr(8'h18, 32'h0f);
    // q_mode is launched the edge after the write lands, so look one later
    @(posedge aclk);
    chk("q_mode", q_mode, 8'h24);
    for (int p = 1; p < 3; p++)
      for (int s = 0; s < 8; s++)
        eg(2'(p), 2'(s), s[2]);
    idle;
    rd(8'h48, {10'h0, 8'h24, 16'(n_mod)});
    for (int k = 0; k < 3; k++)
    begin
      for (int p = 0; p < 3; p++)
      begin
        t = (k + p) % 3;
        st[p] = t == 0 ? 3'h1 : t == 1 ? 3'h0 : 3'h6;
        blk[p] = st[p] == 3'h1;
        wr(8'(8'h10 + 4 * p), st[p]);
      end
      for (int s = 0; s < 16; s++)
        if (s[3:2] != s[1:0])
          fw(s[3:2], s[1:0], s[1:0] == 3 && 1'($urandom));
      i_host.idle;
    end
    lq.push_back({2'h3, 1'b0, st[2][0], st[1][0], st[0][0]});
    wr(8'h44, 32'h30);
    lq.push_back({2'h2, 1'b0, st[2][0], st[1][0], st[0][0]});
    wr(8'h44, 32'h20);
    repeat (3) @(posedge aclk);
    chk("pending", cq.size() + eq.size() + fq.size() + bq.size() +
      rq.size() + lq.size(), 0);
    end_sim;
  end
endmodule // spt_policy_tb_top
`default_nettype wire
